// *** ctu_control.sv ***
// Control and status logic of the charge-time unit: two registers,
// edge qualification into flags, analog control outputs, interrupt.
// Assumes edge sources are synchronous logic levels on clk and that
// pin routing is set up outside before delay generation is enabled.
//
// Functional notes
// R1: Bit 9 grounds the current-source output
// R2: Bit 8 enables the trigger output
// R3: Bit 7 selects second-edge polarity
// R4: Bits 6-5 choose second-edge source
// R5: Bit 4 selects first-edge polarity
// R6: Bits 3-2 choose first-edge source
// R7: Bit 1 flags a second-edge event
// R8: Bit 0 flags a first-edge event
// R9: Software routes pins before delay generation
// R10: Current register low byte reads zero
// R11: Bit 12 turns delay generation on
// R12: Range field 00 disables current source
// R13: Signed trim field, zero is nominal
// R14: Sequencing makes edge two wait for one
// R15: Flags set by hardware, cleared by software
`timescale 1ns/1ps
`default_nettype none
module ctu_control
    import ctu_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic [3:0]  addr,
    input  wire logic [15:0] wdata,
    input  wire logic        wr_en,
    input  wire logic        rd_en,
    output logic [15:0]      rdata,
    input  wire logic        edge_pin_a,
    input  wire logic        edge_pin_b,
    input  wire logic        compare_output_channel,
    input  wire logic        first_timer,
    output logic             unit_enable,
    output logic             delay_generation_enable,
    output logic             source_ground_enable,
    output logic             trigger_output_enable,
    output logic             current_source_on,
    output logic [5:0]       current_trim,
    output logic [1:0]       current_range,
    output logic             irq
);

    ////////////////////////////////////////////////////////////////////
    // Register decode

    logic [15:0]      control_reg;
    logic [15:0]      current_reg;
    logic [15:0]      rdata_reg;
    logic [IRQ_W-1:0] irq_status_reg;
    logic [IRQ_W-1:0] irq_enable_reg;

    wire wr_control = wr_en && (addr == OFF_CONTROL);
    wire wr_current = wr_en && (addr == OFF_CURRENT);
    wire wr_irq_en  = wr_en && (addr == OFF_IRQ_ENABLE);
    wire wr_irq_clr = wr_en && (addr == OFF_IRQ_CLEAR);

    ////////////////////////////////////////////////////////////////////
    // Edge channels

    logic e1_hit;
    logic e2_hit;
    wire  edges_live;
    wire  e1_set;
    wire  e2_set;

    // R6 first-edge source select
    // R5 first-edge polarity
    ctu_edge_detect u_edge1 (
        .clk      (clk),
        .resetn   (resetn),
        .source   (control_reg[B_E1_SRC_HI:B_E1_SRC_LO]),
        .rising   (control_reg[B_E1_POL]),
        .pin_a    (edge_pin_a),
        .pin_b    (edge_pin_b),
        .compare  (compare_output_channel),
        .timer    (first_timer),
        .edge_hit (e1_hit)
    );

    // R4 second-edge source select
    // R3 second-edge polarity
    ctu_edge_detect u_edge2 (
        .clk      (clk),
        .resetn   (resetn),
        .source   (control_reg[B_E2_SRC_HI:B_E2_SRC_LO]),
        .rising   (control_reg[B_E2_POL]),
        .pin_a    (edge_pin_a),
        .pin_b    (edge_pin_b),
        .compare  (compare_output_channel),
        .timer    (first_timer),
        .edge_hit (e2_hit)
    );

    // Edges count only with the unit and edge gate both on
    assign edges_live = control_reg[B_UNIT_EN] & control_reg[B_EDGE_GATE];
    assign e1_set = edges_live & e1_hit;
    // R14 second edge waits for first
    assign e2_set = edges_live & e2_hit &
                    (~control_reg[B_EDGE_SEQ] | control_reg[B_E1_FLAG]);

    ////////////////////////////////////////////////////////////////////
    // Control register next value

    logic [15:0] control_next;
    logic [15:0] control_written;

    assign control_written = wr_control ? (wdata & CONTROL_WMASK) |
                             (control_reg & ~CONTROL_WMASK) : control_reg;

    // R15 flags: set wins over software write
    // R8 first-edge flag
    // R7 second-edge flag
    always_comb begin
        control_next = control_written;
        if (wr_control) begin
            control_next[B_E1_FLAG] = wdata[B_E1_FLAG];
            control_next[B_E2_FLAG] = wdata[B_E2_FLAG];
        end
        if (e1_set) begin
            control_next[B_E1_FLAG] = 1'b1;
        end
        if (e2_set) begin
            control_next[B_E2_FLAG] = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            control_reg <= CONTROL_RESET;
            current_reg <= CURRENT_RESET;
        end else begin
            control_reg <= control_next;
            // R10 low byte never stored
            if (wr_current) begin
                current_reg <= wdata & CURRENT_WMASK;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Interrupt

    logic [IRQ_W-1:0] irq_events;
    logic [IRQ_W-1:0] irq_status_next;

    assign irq_events = {e2_set, e1_set};
    // Set wins over a clear in the same cycle
    assign irq_status_next = (irq_status_reg & ~(wr_irq_clr ? wdata[IRQ_W-1:0] :
                             {IRQ_W{1'b0}})) | irq_events;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            irq_status_reg <= '0;
            irq_enable_reg <= '0;
        end else begin
            irq_status_reg <= irq_status_next;
            if (wr_irq_en) begin
                irq_enable_reg <= wdata[IRQ_W-1:0];
            end
        end
    end

    assign irq = |(irq_status_reg & irq_enable_reg);

    ////////////////////////////////////////////////////////////////////
    // Read port

    logic [15:0] rd_mux;

    assign rd_mux = (addr == OFF_CONTROL)    ? control_reg :
                    (addr == OFF_CURRENT)    ? current_reg :
                    (addr == OFF_IRQ_STATUS) ? {{(16-IRQ_W){1'b0}}, irq_status_reg} :
                    (addr == OFF_IRQ_ENABLE) ? {{(16-IRQ_W){1'b0}}, irq_enable_reg} :
                    16'h0000;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rdata_reg <= 16'h0000;
        end else if (rd_en) begin
            rdata_reg <= rd_mux;
        end else begin
            rdata_reg <= 16'h0000;
        end
    end

    assign rdata = rdata_reg;

    ////////////////////////////////////////////////////////////////////
    // Analog and trigger controls

    assign unit_enable = control_reg[B_UNIT_EN];
    // R11 delay generation enable
    // R9 relies on pins routed beforehand
    assign delay_generation_enable = control_reg[B_DELAY_GEN];
    // R1 ground the source output
    assign source_ground_enable = control_reg[B_SRC_GND];
    // R2 trigger output enable
    assign trigger_output_enable = control_reg[B_TRIG_OUT];
    // R13 signed trim passed to the analog side
    assign current_trim = current_reg[B_TRIM_HI:B_TRIM_LO];
    assign current_range = current_reg[B_RANGE_HI:B_RANGE_LO];
    // R12 range zero disables the source
    assign current_source_on = control_reg[B_UNIT_EN] && (current_range != RANGE_OFF);

    ////////////////////////////////////////////////////////////////////
    // Checks

    sequence s_first_edge;
        e1_set;
    endsequence

    a_first_flag_set: assert property (@(posedge clk) disable iff (!resetn) // R8
        s_first_edge |=> control_reg[B_E1_FLAG])
        else $error("first-edge flag not set after event");

    a_second_flag_set: assert property (@(posedge clk) disable iff (!resetn) // R7
        e2_set |=> control_reg[B_E2_FLAG])
        else $error("second-edge flag not set after event");

    a_flag_holds: assert property (@(posedge clk) disable iff (!resetn) // R15
        (control_reg[B_E1_FLAG] && !wr_control) |=> control_reg[B_E1_FLAG])
        else $error("first-edge flag dropped without a write");

    a_seq_wait: assert property (@(posedge clk) disable iff (!resetn) // R14
        (control_reg[B_EDGE_SEQ] && !control_reg[B_E1_FLAG] && !wr_control)
        |=> $stable(control_reg[B_E2_FLAG]) || !$past(e2_hit) ||
            $past(control_reg[B_E2_FLAG]))
        else $error("second edge taken before first under sequencing");

    a_low_byte_zero: assert property (@(posedge clk) disable iff (!resetn) // R10
        current_reg[7:0] == 8'h00)
        else $error("current register low byte not zero");

    a_ground_follow: assert property (@(posedge clk) disable iff (!resetn) // R1
        (wr_control) |=> source_ground_enable == $past(wdata[B_SRC_GND]))
        else $error("ground control does not follow write");

    a_trig_follow: assert property (@(posedge clk) disable iff (!resetn) // R2
        (wr_control) |=> trigger_output_enable == $past(wdata[B_TRIG_OUT]))
        else $error("trigger enable does not follow write");

    a_range_off: assert property (@(posedge clk) disable iff (!resetn) // R12
        (current_range == RANGE_OFF) |-> !current_source_on)
        else $error("current source on with range zero");

    // Software may clear the status right after, so only one cycle is owed
    a_irq_level: assert property (@(posedge clk) disable iff (!resetn)
        (e1_set && irq_enable_reg[IRQ_E1] && !wr_irq_en) |=> irq)
        else $error("interrupt not raised for enabled event");

    ////////////////////////////////////////////////////////////////////
    // Edge checks, from an independent view of the four sources

    // Bit order follows the source encoding: timer 0 up to pin A 3
    wire [3:0] src_levels = {edge_pin_a, edge_pin_b, compare_output_channel, first_timer};
    wire       e1_level   = src_levels[control_reg[B_E1_SRC_HI:B_E1_SRC_LO]];
    wire       e2_level   = src_levels[control_reg[B_E2_SRC_HI:B_E2_SRC_LO]];
    // A write in either cycle may move the source, so it voids the check
    wire       e1_watch   = edges_live && !wr_control;
    wire       e2_watch   = edges_live && !wr_control &&
                            (!control_reg[B_EDGE_SEQ] || control_reg[B_E1_FLAG]);

    sequence s_e1_edge;
        (e1_watch && (e1_level != control_reg[B_E1_POL])) ##1
        (e1_watch && (e1_level == control_reg[B_E1_POL]));
    endsequence

    sequence s_e1_wrong;
        (e1_watch && (e1_level == control_reg[B_E1_POL])) ##1
        (e1_watch && (e1_level != control_reg[B_E1_POL]) && !control_reg[B_E1_FLAG]);
    endsequence

    sequence s_e2_edge;
        (e2_watch && (e2_level != control_reg[B_E2_POL])) ##1
        (e2_watch && (e2_level == control_reg[B_E2_POL]));
    endsequence

    sequence s_e2_wrong;
        (e2_watch && (e2_level == control_reg[B_E2_POL])) ##1
        (e2_watch && (e2_level != control_reg[B_E2_POL]) && !control_reg[B_E2_FLAG]);
    endsequence

    a_first_edge_taken: assert property (@(posedge clk) disable iff (!resetn) // R5 R6
        s_e1_edge |=> control_reg[B_E1_FLAG])
        else $error("qualified first edge not flagged");

    a_first_edge_wrong: assert property (@(posedge clk) disable iff (!resetn) // R5
        s_e1_wrong |=> !control_reg[B_E1_FLAG])
        else $error("first edge of wrong polarity flagged");

    a_second_edge_taken: assert property (@(posedge clk) disable iff (!resetn) // R3 R4 R14
        s_e2_edge |=> control_reg[B_E2_FLAG])
        else $error("qualified second edge not flagged");

    a_second_edge_wrong: assert property (@(posedge clk) disable iff (!resetn) // R3
        s_e2_wrong |=> !control_reg[B_E2_FLAG])
        else $error("second edge of wrong polarity flagged");

    // Edges are ignored while the unit or the edge gate is off
    a_gate_off_quiet: assert property (@(posedge clk) disable iff (!resetn)
        (!edges_live && !wr_control && !control_reg[B_E1_FLAG] && !control_reg[B_E2_FLAG])
        |=> !control_reg[B_E1_FLAG] && !control_reg[B_E2_FLAG])
        else $error("edge flagged while edges are gated off");

    a_unit_follow: assert property (@(posedge clk) disable iff (!resetn)
        wr_control |=> unit_enable == $past(wdata[B_UNIT_EN]))
        else $error("unit enable does not follow write");

    a_delay_follow: assert property (@(posedge clk) disable iff (!resetn) // R11
        wr_control |=> delay_generation_enable == $past(wdata[B_DELAY_GEN]))
        else $error("delay generation enable does not follow write");

    a_trim_follow: assert property (@(posedge clk) disable iff (!resetn) // R13
        wr_current |=> current_trim == $past(wdata[B_TRIM_HI:B_TRIM_LO]))
        else $error("trim field does not follow write");

    a_range_follow: assert property (@(posedge clk) disable iff (!resetn) // R12
        wr_current |=> current_range == $past(wdata[B_RANGE_HI:B_RANGE_LO]))
        else $error("range field does not follow write");

    a_low_byte_read: assert property (@(posedge clk) disable iff (!resetn) // R10
        (rd_en && (addr == OFF_CURRENT)) |=> rdata[7:0] == 8'h00)
        else $error("current register low byte read not zero");

    a_rdata_idle: assert property (@(posedge clk) disable iff (!resetn)
        !rd_en |=> rdata == 16'h0000)
        else $error("read data not zero outside a read");

    a_first_flag_clear: assert property (@(posedge clk) disable iff (!resetn) // R15
        (wr_control && !wdata[B_E1_FLAG] && !e1_set) |=> !control_reg[B_E1_FLAG])
        else $error("first-edge flag not cleared by write");

    a_second_flag_clear: assert property (@(posedge clk) disable iff (!resetn) // R15
        (wr_control && !wdata[B_E2_FLAG] && !e2_set) |=> !control_reg[B_E2_FLAG])
        else $error("second-edge flag not cleared by write");

    a_irq_clear: assert property (@(posedge clk) disable iff (!resetn)
        (wr_irq_clr && wdata[IRQ_E1] && !e1_set) |=> !irq_status_reg[IRQ_E1])
        else $error("interrupt status not cleared by write");

endmodule
`default_nettype wire

// *** ctu_edge_detect.sv ***
// One edge channel: source select, polarity qualification.
// Assumes all sources are synchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module ctu_edge_detect
    import ctu_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       resetn,
    input  wire logic [1:0] source,
    input  wire logic       rising,
    input  wire logic       pin_a,
    input  wire logic       pin_b,
    input  wire logic       compare,
    input  wire logic       timer,
    output logic            edge_hit
);

    logic sel_level;
    logic last_reg;

    assign sel_level = (source == CTU_SRC_PIN_A)   ? pin_a :
                       (source == CTU_SRC_PIN_B)   ? pin_b :
                       (source == CTU_SRC_COMPARE) ? compare : timer;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            last_reg <= 1'b0;
        end else begin
            last_reg <= sel_level;
        end
    end

    // Changing the source can look like an edge; software should
    // select sources before enabling edges.
    assign edge_hit = rising ? (sel_level & ~last_reg) : (~sel_level & last_reg);

endmodule
`default_nettype wire

// *** ctu_pkg.sv ***
// Package for the charge-time unit control block: register offsets,
// field positions, reset values and source encodings.
// Assumes a 16-bit register port on the system clock.
package ctu_pkg;

    localparam int unsigned ADDR_W = 4;
    localparam int unsigned DATA_W = 16;

    // Register offsets (word index on the plain port)
    localparam logic [3:0] OFF_CONTROL = 4'h0;
    localparam logic [3:0] OFF_CURRENT = 4'h1;
    localparam logic [3:0] OFF_IRQ_STATUS = 4'h2;
    localparam logic [3:0] OFF_IRQ_ENABLE = 4'h3;
    localparam logic [3:0] OFF_IRQ_CLEAR = 4'h4;

    localparam logic [15:0] CONTROL_RESET = 16'h0000;
    localparam logic [15:0] CURRENT_RESET = 16'h0000;

    // Control register field positions
    localparam int unsigned B_UNIT_EN = 15;
    localparam int unsigned B_DELAY_GEN = 12;
    localparam int unsigned B_EDGE_GATE = 11;
    localparam int unsigned B_EDGE_SEQ = 10;
    localparam int unsigned B_SRC_GND = 9;
    localparam int unsigned B_TRIG_OUT = 8;
    localparam int unsigned B_E2_POL = 7;
    localparam int unsigned B_E2_SRC_HI = 6;
    localparam int unsigned B_E2_SRC_LO = 5;
    localparam int unsigned B_E1_POL = 4;
    localparam int unsigned B_E1_SRC_HI = 3;
    localparam int unsigned B_E1_SRC_LO = 2;
    localparam int unsigned B_E2_FLAG = 1;
    localparam int unsigned B_E1_FLAG = 0;

    // Writable bits of the control register; bit 14 reads zero
    localparam logic [15:0] CONTROL_WMASK = 16'hbffc;
    // Current register: trim 15-10, range 9-8, low byte reads zero
    localparam logic [15:0] CURRENT_WMASK = 16'hff00;
    localparam int unsigned B_TRIM_HI = 15;
    localparam int unsigned B_TRIM_LO = 10;
    localparam int unsigned B_RANGE_HI = 9;
    localparam int unsigned B_RANGE_LO = 8;

    localparam logic [1:0] RANGE_OFF = 2'h0;

    typedef enum logic [1:0] {
        CTU_SRC_TIMER = 2'h0,
        CTU_SRC_COMPARE = 2'h1,
        CTU_SRC_PIN_B = 2'h2,
        CTU_SRC_PIN_A = 2'h3
    } ctu_src_t;

    // Interrupt status bit positions
    localparam int unsigned IRQ_E1 = 0;
    localparam int unsigned IRQ_E2 = 1;
    localparam int unsigned IRQ_W = 2;

endpackage

// *** ctu_source_model.sv ***
// Far-side model: first timer, compare channel and the two edge pins.
// Assumes the bench loads new levels with a one-cycle strobe.
`timescale 1ns/1ps
`default_nettype none
module ctu_source_model (
    input  wire logic       clk,
    input  wire logic       resetn,
    input  wire logic       load,
    input  wire logic [3:0] levels,
    output logic            first_timer,
    output logic            compare_output_channel,
    output logic            edge_pin_b,
    output logic            edge_pin_a
);
    logic [3:0] lv_reg;

    // routing fixed before enable
    // Lines move only on the clock, as on-chip sources do
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            lv_reg <= 4'h0;
        end else if (load) begin
            lv_reg <= levels;
        end
    end
    assign {edge_pin_a, edge_pin_b, compare_output_channel, first_timer} = lv_reg;
endmodule
`default_nettype wire

// *** tb_edge_timing_control_unit.sv ***
// Self-checking bench for the charge-time unit control block.
// Assumes the source model drives the four edge sources.
`timescale 1ns/1ps
`default_nettype none
module tb_edge_timing_control_unit;
    import ctu_pkg::*;
    typedef struct { string name; logic [15:0] exp; } ctu_note_t;

    logic        clk, resetn, wr_en, rd_en, load, pend;
    logic [3:0]  addr, levels, act, sel;
    logic [15:0] wdata, rdata, cfg;
    logic [5:0]  tv, current_trim;
    logic [1:0]  current_range;
    logic        pin_a, pin_b, cmp, tmr, irq, current_source_on;
    logic        unit_enable, delay_generation_enable;
    logic        source_ground_enable, trigger_output_enable;
    int          fails, n_compared;
    ctu_note_t   notes[$];

    ctu_control u_ctu_control (.clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata),
        .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .edge_pin_a(pin_a),
        .edge_pin_b(pin_b), .compare_output_channel(cmp), .first_timer(tmr),
        .unit_enable(unit_enable), .delay_generation_enable(delay_generation_enable),
        .source_ground_enable(source_ground_enable),
        .trigger_output_enable(trigger_output_enable),
        .current_source_on(current_source_on), .current_trim(current_trim),
        .current_range(current_range), .irq(irq));
    ctu_source_model u_ctu_source_model (.clk(clk), .resetn(resetn), .load(load),
        .levels(levels), .first_timer(tmr), .compare_output_channel(cmp),
        .edge_pin_b(pin_b), .edge_pin_a(pin_a));

    always #20 clk = ~clk;

    ////////////////////////////////////////////////////////////////////////
    task automatic end_of_test();
        $display("compared %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        n_compared++;
        if (g !== e) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask
    task automatic rd(input string n, input logic [3:0] a, input logic [15:0] e);
        ctu_note_t t;
        t.name = n;
        t.exp = e;
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        notes.push_back(t);
        @(posedge clk);
        rd_en <= 1'b0;
    endtask
    task automatic mv(input logic [3:0] v);
        @(posedge clk);
        levels <= v;
        load <= 1'b1;
        @(posedge clk);
        load <= 1'b0;
        tick(3);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Read data stand only in the cycle after the strobe
    always @(posedge clk) begin
        ctu_note_t t;
        if (pend && notes.size() > 0) begin
            t = notes.pop_front();
            chk(t.name, t.exp, rdata);
        end
        pend <= rd_en;
    end

    initial begin
        #400000;
        fails++;
        end_of_test();
    end

    initial begin
        {clk, resetn, wr_en, rd_en, load, addr, wdata, levels} = '0;
        fails = 0;
        n_compared = 0;
        void'($urandom(32'hb086));
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        rd("control", OFF_CONTROL, CONTROL_RESET);
        rd("current", OFF_CURRENT, CURRENT_RESET);
        rd("status", OFF_IRQ_STATUS, 16'h0000);
        chk("unit enable", 16'h0, 16'(unit_enable));
        wr(4'h9, 16'hffff);
        rd("unmapped", 4'h9, 16'h0000);
        rd("clear reads", OFF_IRQ_CLEAR, 16'h0000);
        wr(OFF_CONTROL, 16'hfffc);
        tick(1);
        chk("ground", 16'h1, 16'(source_ground_enable));
        chk("trigger", 16'h1, 16'(trigger_output_enable));
        chk("delay gen", 16'h1, 16'(delay_generation_enable));
        chk("unit enable", 16'h1, 16'(unit_enable));
        rd("control", OFF_CONTROL, 16'hbffc);
        wr(OFF_CONTROL, 16'h8000);
        tick(1);
        chk("ground", 16'h0, 16'(source_ground_enable));
        chk("trigger", 16'h0, 16'(trigger_output_enable));
        chk("delay gen", 16'h0, 16'(delay_generation_enable));
        for (int r = 0; r < 4; r++) begin
            tv = 6'($urandom());
            wr(OFF_CURRENT, {tv, 2'(r), 8'hff});
            tick(1);
            chk("source on", 16'(r != 0), 16'(current_source_on));
            chk("trim", 16'(tv), 16'(current_trim));
            chk("range", 16'(r), 16'(current_range));
            rd("current", OFF_CURRENT, {tv, 2'(r), 8'h00});
        end
        // Edge one runs with sequencing so edge two stays quiet
        wr(OFF_IRQ_ENABLE, 16'h0003);
        for (int e = 0; e < 2; e++) begin
            for (int s = 0; s < 4; s++) begin
                for (int p = 0; p < 2; p++) begin
                    act = p ? 4'hf : 4'h0;
                    sel = 4'h1 << s;
                    cfg = e ? (16'h8800 | 16'(p) << 7 | 16'(s) << 5 | 16'(s ^ 1) << 2)
                            : (16'h8c00 | 16'(p) << 4 | 16'(s) << 2);
                    wr(OFF_CONTROL, 16'h0000);
                    mv(act);
                    wr(OFF_CONTROL, cfg);
                    mv(act ^ sel);
                    rd("wrong edge", OFF_CONTROL, cfg);
                    mv(act);
                    rd("edge flag", OFF_CONTROL, cfg | 16'(1 << e));
                    chk("irq", 16'h1, 16'(irq));
                    rd("status", OFF_IRQ_STATUS, 16'(1 << e));
                    wr(OFF_IRQ_CLEAR, 16'h0003);
                    wr(OFF_CONTROL, cfg);
                    tick(1);
                    chk("irq", 16'h0, 16'(irq));
                    rd("cleared", OFF_CONTROL, cfg);
                end
            end
        end
        wr(OFF_CONTROL, 16'h0000);
        mv(4'h0);
        wr(OFF_IRQ_ENABLE, 16'h0000);
        wr(OFF_CONTROL, 16'h8cdc);
        mv(4'h4);
        rd("seq hold", OFF_CONTROL, 16'h8cdc);
        mv(4'h8);
        mv(4'hc);
        rd("seq pass", OFF_CONTROL, 16'h8cdf);
        chk("masked irq", 16'h0, 16'(irq));
        rd("status", OFF_IRQ_STATUS, 16'h0003);
        tick(2);
        end_of_test();
    end
endmodule
`default_nettype wire
